/* logic/afs_pkg.sv */
// Shared constants and types of the converter serial and cascade port.
// Assumes clk_in is the master clock; every module except afs_dsp_model imports this package.
package afs_pkg;
  localparam int WORD_W = 16;
  localparam int CH_N = 6;
  localparam int CIC_ORDER = 3;
  localparam int CIC_DEC_LOG2 = 5;
  localparam int MOD_DIV = 8;
  localparam logic [2:0] MOD_LAST = 3'(MOD_DIV - 1);
  localparam int BASE_DIV = 256;
  localparam int DEFAULT_DIV = 2048;
  localparam logic [3:0] DEFAULT_LAST = 4'(DEFAULT_DIV / BASE_DIV - 1);
  localparam logic [1:0] SCK_SLOW_LAST = 2'h3;
  localparam logic [1:0] SCK_FAST_LAST = 2'h1;
  localparam logic [2:0] REG_MAIN = 3'h0;
  localparam logic [2:0] REG_RATE = 3'h1;
  localparam logic [2:0] REG_CHAN = 3'h2;
  localparam logic [2:0] REG_STAT = 3'h3;
  localparam int MAIN_DPS = 0;
  localparam int MAIN_MM = 1;
  localparam int MAIN_CASC = 2;
  localparam int MAIN_SRST = 7;
  localparam int RATE_DEC = 0;
  localparam int RATE_DIV = 2;
  localparam int RATE_SCK = 4;
  localparam int CW_FLAG = 15;
  localparam int CW_ADDR = 11;
  localparam int CW_REG = 8;
  localparam logic [7:0] MAIN_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h00;
  localparam logic [5:0] CHAN_RST = 6'h00;
  localparam logic [5:0] CHAN_ONE = 6'h01;
  localparam logic [4:0] IN_ARM = 5'h10;
  typedef enum logic [3:0] {
    OS_IDLE = 4'h1,
    OS_SYNC = 4'h2,
    OS_START = 4'h4,
    OS_SHIFT = 4'h8
  } afs_os_e;
endpackage

/* logic/afs_tick_if.sv */
// Timing strobes from the clock divider to the converter and serial logic.
// mod_tick and rise are one-cycle pulses on clk_in; dm_tick is a strobe that stays high at divider setting zero; sclk is a level.
`timescale 1ns/1ps
interface afs_tick_if;
  logic dm_tick;
  logic mod_tick;
  logic sclk;
  logic rise;
  modport src (output dm_tick, mod_tick, sclk, rise);
  modport dst (input dm_tick, mod_tick, sclk, rise);
endinterface

/* logic/afs_clkgen.sv */
// Divided master clock, modulator tick and serial clock generator.
// Assumes run_in is already synchronised to clk_in.
`timescale 1ns/1ps
module afs_clkgen
  import afs_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [1:0] div_in,
  input wire logic [1:0] sck_in,
  input wire logic run_in,
  afs_tick_if.src tick_out
);
  typedef struct packed {
    logic [1:0] dm_cnt;
    logic [2:0] mod_cnt;
    logic [1:0] sck_cnt;
    logic sclk;
    logic dm_tick;
    logic mod_tick;
    logic rise;
  } afs_clk_s;

  afs_clk_s q_ff;
  afs_clk_s nxt_q;
  logic [1:0] half_last;

  // Counters restart only from reset or a stopped enable, so chained parts agree in phase.
  always_comb
  begin
    nxt_q = q_ff;
    half_last = (sck_in == 2'h0) ? SCK_SLOW_LAST : SCK_FAST_LAST;
    nxt_q.dm_tick = 1'b0;
    nxt_q.mod_tick = 1'b0;
    nxt_q.rise = 1'b0;
    if (q_ff.dm_cnt >= div_in)
    begin
      nxt_q.dm_cnt = 2'h0;
      nxt_q.dm_tick = 1'b1;
    end
    else
      nxt_q.dm_cnt = q_ff.dm_cnt + 2'h1;
    if (q_ff.dm_tick)
    begin
      nxt_q.mod_cnt = q_ff.mod_cnt + 3'h1;
      nxt_q.mod_tick = (q_ff.mod_cnt == MOD_LAST);
      if (!run_in)
      begin
        nxt_q.sck_cnt = 2'h0;
        nxt_q.sclk = 1'b0;
      end
      else if (q_ff.sck_cnt >= half_last)
      begin
        nxt_q.sck_cnt = 2'h0;
        nxt_q.sclk = !q_ff.sclk;
        nxt_q.rise = !q_ff.sclk;
      end
      else
        nxt_q.sck_cnt = q_ff.sck_cnt + 2'h1;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      q_ff <= '0;
    else
      q_ff <= nxt_q;
  end

  assign tick_out.dm_tick = q_ff.dm_tick;
  assign tick_out.mod_tick = q_ff.mod_tick;
  assign tick_out.sclk = q_ff.sclk;
  assign tick_out.rise = q_ff.rise;

  a_sclk_stops: assert property (@(posedge clk_in) disable iff (reset_in)
    (!run_in && q_ff.dm_tick) |=> !q_ff.sclk)
    else $error("serial clock runs while disabled");
  a_mod_spacing: assert property (@(posedge clk_in) disable iff (reset_in)
    q_ff.mod_tick |=> !q_ff.mod_tick [*7])
    else $error("modulator ticks too close");
endmodule

/* logic/afs_cic.sv */
// One third-order comb-integrator decimator for a one-bit modulator stream.
// Assumes bit_in is synchronised and tick_in.mod_tick marks each modulator bit.
`timescale 1ns/1ps
module afs_cic
  import afs_pkg::*;
#(
  parameter int DEC_LOG2 = CIC_DEC_LOG2,
  parameter int OUT_W = WORD_W
)
(
  input wire logic clk_in,
  input wire logic reset_in,
  afs_tick_if.dst tick_in,
  input wire logic bit_in,
  output logic [OUT_W-1:0] word_out,
  output logic done_out
);
  if (OUT_W != 1 + CIC_ORDER * DEC_LOG2)
  begin : g_bad_width
    $error("decimator width does not fit its order and factor");
  end

  typedef struct packed {
    logic [OUT_W-1:0] i1;
    logic [OUT_W-1:0] i2;
    logic [OUT_W-1:0] i3;
    logic [OUT_W-1:0] c1;
    logic [OUT_W-1:0] c2;
    logic [OUT_W-1:0] c3;
    logic [OUT_W-1:0] word;
    logic [DEC_LOG2-1:0] cnt;
    logic done;
  } afs_cic_s;

  afs_cic_s q_ff;
  afs_cic_s nxt_q;
  logic [OUT_W-1:0] y1;
  logic [OUT_W-1:0] y2;

  // Wrapping arithmetic is intended: the comb differences cancel the overflow.
  always_comb
  begin
    nxt_q = q_ff;
    y1 = q_ff.i3 - q_ff.c1;
    y2 = y1 - q_ff.c2;
    nxt_q.done = 1'b0;
    if (tick_in.mod_tick)
    begin
      nxt_q.i1 = q_ff.i1 + {{(OUT_W-1){1'b0}}, bit_in};
      nxt_q.i2 = q_ff.i2 + q_ff.i1;
      nxt_q.i3 = q_ff.i3 + q_ff.i2;
      nxt_q.cnt = q_ff.cnt + 1'b1;
      if (&q_ff.cnt)
      begin
        nxt_q.c1 = q_ff.i3;
        nxt_q.c2 = y1;
        nxt_q.c3 = y2;
        nxt_q.word = y2 - q_ff.c3;
        nxt_q.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      q_ff <= '0;
    else
      q_ff <= nxt_q;
  end

  assign word_out = q_ff.word;
  assign done_out = q_ff.done;

  a_dump_rate: assert property (@(posedge clk_in) disable iff (reset_in)
    (tick_in.mod_tick && (&q_ff.cnt)) |=> q_ff.done)
    else $error("decimator missed its output instant");
endmodule

/* logic/afs_frontend_top.sv */
// Serial port, cascade sequencing and rate control of a six-channel converter.
// Assumes clk_in is the master clock; pins and modulator bits are asynchronous.
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
// Contract
// - Every 16-bit word has a high frame pulse one bit before its MSB.
// - The device drives the serial clock that paces both directions.
// - Direct coupling: input words shift in together with output words.
// - Three-bit cascade count holds devices minus one, reset to zero.
// - Per channel the own word goes first, then upstream words forwarded.
// - One extra frame bit precedes each next channel after the cascade words.
// - Upstream output and frame feed this device's input and frame.
// - Equal reset and enable give equal serial clock frequency and phase.
// - Modulator rate is the divided clock over eight.
// - Decimation setting picks 64, 32, 16 or 8 kHz sample rates.
// - Clock divider setting lowers the divided master clock.
// - Third-order decimator, factor 32, at the divided clock over eight.
// - Control word with address zero is taken, else decremented and forwarded.
// - Mixed mode: input MSB flags control; output words carry MSB zero.
// - Frames run at divided clock over 2048 until the rate register is written.
module afs_frontend_top
  import afs_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic port_enable_pin_in,
  input wire logic serial_in_in,
  input wire logic serial_in_frame_in,
  input wire logic [CH_N-1:0] mod_bits_in,
  output logic sclk_out,
  output logic serial_out_out,
  output logic serial_out_frame_out,
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out
);
  localparam int SYNC_W = CH_N + 3;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    afs_os_e os;
    logic [7:0] main;
    logic [7:0] rate;
    logic [CH_N-1:0] chan;
    logic rate_wr;
    logic [3:0] base_cnt;
    logic [2:0] ch;
    logic [2:0] fwd_left;
    logic [3:0] bit_cnt;
    logic [WORD_W-1:0] sh_out;
    logic sout;
    logic sframe;
    logic [4:0] in_cnt;
    logic [WORD_W-1:0] sh_in;
    logic [WORD_W-1:0] hold;
    logic [CH_N-1:0][WORD_W-1:0] samp;
    logic [7:0] rdata;
  } afs_st_s;

  afs_st_s st_ff;
  afs_st_s nxt_st;
  logic sin;
  logic sfr;
  logic en;
  logic [CH_N-1:0] mod_sync;
  logic [CH_N-1:0] cic_done;
  logic [WORD_W-1:0] cic_word [CH_N];
  logic base_tick;
  logic samp_tick;
  logic [3:0] base_last;
  logic [2:0] casc;
  logic dps;
  logic mm;
  logic ctl;
  logic wdone;
  logic [WORD_W-1:0] w;
  logic [WORD_W-1:0] word;
  logic [3:0] nxt_ch;

  afs_tick_if tick ();

  // Both the register port and incoming control words use this write decode.
  function automatic afs_st_s write_reg(afs_st_s s, logic [2:0] idx, logic [7:0] d);
    afs_st_s r;
    r = s;
    case (idx)
      REG_MAIN:
      begin
        if (d[MAIN_SRST])
        begin
          r.main = MAIN_RST;
          r.rate = RATE_RST;
          r.chan = CHAN_RST;
          r.rate_wr = 1'b0;
        end
        else
          r.main = d;
      end
      REG_RATE:
      begin
        r.rate = d;
        r.rate_wr = 1'b1;
      end
      REG_CHAN: r.chan = d[CH_N-1:0];
      default: r = s;
    endcase
    return r;
  endfunction

  // First enabled channel above the current one, with a found flag on top.
  function automatic logic [3:0] next_enabled(logic [CH_N-1:0] mask, logic [2:0] cur);
    logic [3:0] r;
    r = 4'h0;
    for (int i = CH_N - 1; i >= 0; i--)
    begin
      if (mask[i] && (i > int'(cur)))
        r = {1'b1, 3'(i)};
    end
    return r;
  endfunction

  afs_clkgen u_clkgen (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .div_in(st_ff.rate[RATE_DIV+:2]),
    .sck_in(st_ff.rate[RATE_SCK+:2]),
    .run_in(en),
    .tick_out(tick)
  );

  for (genvar g = 0; g < CH_N; g++)
  begin : g_cic
    afs_cic u_cic (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .tick_in(tick),
      .bit_in(mod_sync[g]),
      .word_out(cic_word[g]),
      .done_out(cic_done[g])
    );
  end

  assign sin = st_ff.s2[0];
  assign sfr = st_ff.s2[1];
  assign en = st_ff.s2[2];
  assign mod_sync = st_ff.s2[SYNC_W-1:3];
  assign base_tick = cic_done[0];
  assign casc = st_ff.main[MAIN_CASC+:3];
  assign dps = st_ff.main[MAIN_DPS];
  assign mm = st_ff.main[MAIN_MM];

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s1 = {mod_bits_in, port_enable_pin_in, serial_in_frame_in, serial_in_in};
    nxt_st.s2 = st_ff.s1;
    nxt_st.rdata = 8'h00;
    wdone = 1'b0;
    ctl = 1'b0;
    w = {st_ff.sh_in[WORD_W-2:0], sin};
    nxt_ch = next_enabled(st_ff.chan | CHAN_ONE, st_ff.ch);
    word = st_ff.samp[st_ff.ch];
    if (dps && mm)
      word = {1'b0, st_ff.samp[st_ff.ch][WORD_W-1:1]};
    base_last = DEFAULT_LAST;
    if (st_ff.rate_wr)
      base_last = (4'h1 << st_ff.rate[RATE_DEC+:2]) - 4'h1;
    samp_tick = base_tick && (st_ff.base_cnt >= base_last);
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        REG_MAIN: nxt_st.rdata = st_ff.main;
        REG_RATE: nxt_st.rdata = st_ff.rate;
        REG_CHAN: nxt_st.rdata = {2'h0, st_ff.chan};
        REG_STAT: nxt_st.rdata = {st_ff.rate_wr, st_ff.os == OS_IDLE, en, 2'h0, casc};
        default: nxt_st.rdata = 8'h00;
      endcase
    end
    if (reg_wr_in)
      nxt_st = write_reg(nxt_st, reg_addr_in, reg_wdata_in);
    // Input bits are taken at the rise that ends their bit period, which leaves room
    // for the pin synchroniser; the fastest serial clock still allows it.
    if (tick.rise)
    begin
      if (st_ff.in_cnt != 5'h0)
      begin
        nxt_st.sh_in = w;
        nxt_st.in_cnt = st_ff.in_cnt - 5'h1;
        wdone = (st_ff.in_cnt == 5'h1);
      end
      if (sfr && (st_ff.in_cnt <= 5'h1))
        nxt_st.in_cnt = IN_ARM;
    end
    if (wdone)
    begin
      ctl = !dps || (mm && w[CW_FLAG]);
      nxt_st.hold = w;
      if (ctl && (w[CW_ADDR+:3] == 3'h0))
        nxt_st = write_reg(nxt_st, w[CW_REG+:3], w[7:0]);
      else if (ctl)
        nxt_st.hold[CW_ADDR+:3] = w[CW_ADDR+:3] - 3'h1;
    end
    if (base_tick)
      nxt_st.base_cnt = samp_tick ? 4'h0 : st_ff.base_cnt + 4'h1;
    // A sample that falls inside a busy frame is dropped rather than torn.
    if (samp_tick && en && (st_ff.os == OS_IDLE))
    begin
      for (int c = 0; c < CH_N; c++)
        nxt_st.samp[c] = cic_word[c];
      nxt_st.os = OS_SYNC;
    end
    if (!en)
    begin
      nxt_st.os = OS_IDLE;
      nxt_st.sframe = 1'b0;
      nxt_st.sout = 1'b0;
      nxt_st.in_cnt = 5'h0;
    end
    else if (tick.rise)
    begin
      unique case (st_ff.os)
        OS_IDLE:
        begin
          nxt_st.sframe = 1'b0;
          nxt_st.sout = 1'b0;
        end
        OS_SYNC:
        begin
          nxt_st.sframe = 1'b1;
          nxt_st.sout = 1'b0;
          nxt_st.ch = 3'h0;
          nxt_st.os = OS_START;
        end
        OS_START:
        begin
          nxt_st.sout = word[WORD_W-1];
          nxt_st.sh_out = {word[WORD_W-2:0], 1'b0};
          nxt_st.bit_cnt = 4'hF;
          nxt_st.fwd_left = casc;
          nxt_st.sframe = 1'b0;
          nxt_st.os = OS_SHIFT;
        end
        OS_SHIFT:
        begin
          if (st_ff.bit_cnt != 4'h0)
          begin
            nxt_st.sout = st_ff.sh_out[WORD_W-1];
            nxt_st.sh_out = {st_ff.sh_out[WORD_W-2:0], 1'b0};
            nxt_st.bit_cnt = st_ff.bit_cnt - 4'h1;
            nxt_st.sframe = (st_ff.bit_cnt == 4'h1) && (st_ff.fwd_left != 3'h0);
          end
          else if (st_ff.fwd_left != 3'h0)
          begin
            word = wdone ? w : st_ff.hold;
            nxt_st.sout = word[WORD_W-1];
            nxt_st.sh_out = {word[WORD_W-2:0], 1'b0};
            nxt_st.bit_cnt = 4'hF;
            nxt_st.fwd_left = st_ff.fwd_left - 3'h1;
            nxt_st.sframe = 1'b0;
          end
          else if (nxt_ch[3])
          begin
            nxt_st.ch = nxt_ch[2:0];
            nxt_st.sframe = 1'b1;
            nxt_st.sout = 1'b0;
            nxt_st.os = OS_START;
          end
          else
          begin
            nxt_st.sframe = 1'b0;
            nxt_st.sout = 1'b0;
            nxt_st.os = OS_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      st_ff <= '0;
      st_ff.os <= OS_IDLE;
    end
    else
      st_ff <= nxt_st;
  end

  assign sclk_out = tick.sclk;
  assign serial_out_out = st_ff.sout;
  assign serial_out_frame_out = st_ff.sframe;
  assign reg_rdata_out = st_ff.rdata;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  a_frame_before_msb: assert property (
    (tick.rise && en && (st_ff.os == OS_START)) |-> st_ff.sframe)
    else $error("word started without a preceding frame bit");
  a_mixed_msb_zero: assert property (
    (tick.rise && en && (st_ff.os == OS_START) && dps && mm) |=> !st_ff.sout)
    else $error("mixed mode output word has MSB set");
  a_casc_soft_reset: assert property (
    (reg_wr_in && (reg_addr_in == REG_MAIN) && reg_wdata_in[MAIN_SRST]) |=> (casc == 3'h0))
    else $error("cascade count not cleared by soft reset");
  a_default_rate: assert property (
    (samp_tick && !st_ff.rate_wr) |-> (st_ff.base_cnt == DEFAULT_LAST))
    else $error("default frame rate not used before rate write");
  a_fwd_count: assert property (
    (tick.rise && en && (st_ff.os == OS_SHIFT) && (st_ff.bit_cnt == 4'h0)
      && (st_ff.fwd_left != 3'h0))
    |=> (st_ff.fwd_left == $past(st_ff.fwd_left) - 3'h1) && (st_ff.bit_cnt == 4'hF))
    else $error("forwarded word slot not taken");
  a_extra_bit: assert property (
    (tick.rise && en && (st_ff.os == OS_SHIFT) && (st_ff.bit_cnt == 4'h0)
      && (st_ff.fwd_left == 3'h0) && nxt_ch[3])
    |=> st_ff.sframe && !st_ff.sout && (st_ff.os == OS_START))
    else $error("missing extra frame bit before next channel");
  a_addr_decrement: assert property (
    (wdone && ctl && (w[CW_ADDR+:3] != 3'h0))
    |=> (st_ff.hold[CW_ADDR+:3] == $past(w[CW_ADDR+:3]) - 3'h1))
    else $error("forwarded control word address not decremented");
  a_word_length: assert property (
    (tick.rise && en && (st_ff.os == OS_START)) |=> (st_ff.bit_cnt == 4'hF) [*3])
    else $error("word shift count wrong at start");
  a_rate_applied: assert property (
    (reg_wr_in && (reg_addr_in == REG_RATE)) |=> st_ff.rate_wr)
    else $error("rate write not recorded");

  c_sample_start: cover property (samp_tick && en && (st_ff.os == OS_IDLE));
  c_cascade_fwd: cover property (tick.rise && (st_ff.os == OS_SHIFT) && (st_ff.fwd_left != 3'h0)
    && (st_ff.bit_cnt == 4'h0));
  c_control_taken: cover property (wdone && ctl && (w[CW_ADDR+:3] == 3'h0));
  c_next_channel: cover property (tick.rise && (st_ff.os == OS_SHIFT) && nxt_ch[3]);
endmodule

/* bench/afs_dsp_model.sv */
// Controller serial port model: sends control words and collects output words.
// Assumes sclk_in comes from the converter, which launches its bits after each rising edge.
`timescale 1ns/1ps
module afs_dsp_model
(
  input wire logic sclk_in,
  input wire logic serial_out_in,
  input wire logic frame_out_in,
  input wire logic direct_in,
  input wire logic [15:0] tx_word_in,
  input wire logic tx_go_in,
  output logic serial_in_out,
  output logic serial_in_frame_out,
  output logic tx_busy_out,
  output logic [15:0] rx_word_out
);
  // Sent in loop-back slots when nothing is queued; its address is never zero.
  localparam logic [15:0] IDLE_WORD = 16'h3800;
  logic [4:0] tx_cnt = 5'h00;
  logic [4:0] rx_cnt = 5'h00;
  logic [15:0] tx_sh = 16'h0000;
  logic [15:0] rx_sh = 16'h0000;
  logic tx_frm = 1'b0;
  initial
  begin
    serial_in_out = 1'b0;
    rx_word_out = 16'h0000;
  end
  assign serial_in_frame_out = direct_in ? frame_out_in : tx_frm;
  assign tx_busy_out = tx_frm | (tx_cnt != 5'h00);
  // Both directions move on the falling edge, half a bit away from the converter's launch.
  always @(negedge sclk_in)
  begin
    tx_frm <= 1'b0;
    if (tx_cnt != 5'h00)
    begin
      serial_in_out <= tx_sh[15];
      tx_sh <= {tx_sh[14:0], 1'b0};
      tx_cnt <= tx_cnt - 5'h01;
    end
    else
      serial_in_out <= ~serial_in_out; // A released line must never look like a held bit.
    if (direct_in ? frame_out_in : (tx_go_in && tx_cnt == 5'h00 && !tx_frm))
    begin
      tx_sh <= (direct_in && !tx_go_in) ? IDLE_WORD : tx_word_in;
      tx_cnt <= 5'h10;
      tx_frm <= !direct_in;
    end
  end
  always @(negedge sclk_in)
  begin
    if (rx_cnt != 5'h00)
    begin
      rx_sh <= {rx_sh[14:0], serial_out_in};
      rx_cnt <= rx_cnt - 5'h01;
      if (rx_cnt == 5'h01)
        rx_word_out <= {rx_sh[14:0], serial_out_in};
    end
    if (frame_out_in)
      rx_cnt <= 5'h10;
  end
endmodule

/* bench/testbench.sv */
// Self-checking bench for the converter serial port, cascade slots and rate settings.
// Assumes a 100 MHz master clock; the controller port model sits on the serial pins.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s expected %0h seen %0h", nm, e, g); end end
module testbench
  import afs_pkg::*;
;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic port_enable_pin_in = 1'b1;
  logic [CH_N-1:0] mod_bits_in = 6'h00;
  logic [2:0] reg_addr_in = 3'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  // The first control word is queued before reset ends, so it meets the first output word.
  logic loop_back = 1'b1;
  logic tx_go = 1'b1;
  logic [WORD_W-1:0] tx_word = 16'h0102;
  logic sclk_out, serial_out_out, serial_out_frame_out, serial_in_in, serial_in_frame_in;
  logic tx_busy;
  logic [7:0] reg_rdata_out;
  logic [WORD_W-1:0] rx_word;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int t, w, p, a, b, c, n;
  afs_frontend_top u_afs_frontend_top (
    .clk_in(clk_in), .reset_in(reset_in), .port_enable_pin_in(port_enable_pin_in),
    .serial_in_in(serial_in_in), .serial_in_frame_in(serial_in_frame_in),
    .mod_bits_in(mod_bits_in), .sclk_out(sclk_out), .serial_out_out(serial_out_out),
    .serial_out_frame_out(serial_out_frame_out), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out));
  afs_dsp_model u_afs_dsp_model (
    .sclk_in(sclk_out), .serial_out_in(serial_out_out), .frame_out_in(serial_out_frame_out),
    .direct_in(loop_back), .tx_word_in(tx_word), .tx_go_in(tx_go),
    .serial_in_out(serial_in_in), .serial_in_frame_out(serial_in_frame_in),
    .tx_busy_out(tx_busy), .rx_word_out(rx_word));
  initial
  begin
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
    cyc <= cyc + 1;
  task wr(input logic [2:0] ad, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in <= ad;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task rd_chk(input logic [2:0] ad, input logic [7:0] e);
    @(posedge clk_in);
    reg_addr_in <= ad;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    `CHK("register read", e, reg_rdata_out)
    @(posedge clk_in);
    #1;
    `CHK("read data release", 8'h00, reg_rdata_out)
  endtask
  task wait_busy(input logic v);
    int k;
    k = 0;
    while (tx_busy !== v && k < 6000)
    begin
      @(posedge clk_in);
      k++;
    end
    `CHK("controller port busy", v, tx_busy)
  endtask
  // Returns the cycle of the next output frame rise and how many cycles it stayed high.
  task frame_rise(output int tr, output int wd);
    int k;
    k = 0;
    while (serial_out_frame_out !== 1'b0 && k < 9000)
    begin
      @(posedge clk_in);
      k++;
    end
    while (serial_out_frame_out !== 1'b1 && k < 9000)
    begin
      @(posedge clk_in);
      k++;
    end
    tr = cyc;
    wd = 0;
    while (serial_out_frame_out === 1'b1 && wd < 64)
    begin
      @(posedge clk_in);
      wd++;
    end
    `CHK("output frame seen", 1'b1, k < 9000)
  endtask
  task period_chk(input int per, input int wid);
    frame_rise(a, w);
    frame_rise(a, w);
    frame_rise(b, w);
    `CHK("sample period", per, b - a)
    `CHK("frame width", wid, w)
  endtask
  task send(input logic [15:0] wd);
    tx_word <= wd;
    @(posedge clk_in);
    tx_go <= 1'b1;
    wait_busy(1'b1);
    tx_go <= 1'b0;
    wait_busy(1'b0);
    repeat (2) @(negedge sclk_out);
  endtask
  task word_chk(input logic [15:0] e);
    repeat (6) frame_rise(a, w);
    `CHK("converter word", e, rx_word)
  endtask
  task t_loop_back;
    wait_busy(1'b1);
    tx_go <= 1'b0;
    wait_busy(1'b0);
    repeat (2) @(negedge sclk_out);
    rd_chk(3'h1, 8'h02);
    period_chk(1024, 8);
    loop_back <= 1'b0;
  endtask
  task t_soft_reset;
    wr(3'h0, 8'h80);
    rd_chk(3'h1, 8'h00);
    rd_chk(3'h0, 8'h00);
    rd_chk(3'h2, 8'h00);
    wr(3'h5, 8'hFF);
    rd_chk(3'h5, 8'h00);
    period_chk(2048, 8);
  endtask
  task t_rates;
    for (int d = 0; d < 4; d++)
    begin
      wr(3'h1, {6'h00, 2'(d)});
      period_chk(256 << d, 8);
    end
    wr(3'h1, 8'h04);
    period_chk(512, 16);
    wr(3'h1, 8'h10);
    period_chk(256, 4);
  endtask
  task t_control;
    send(16'h0205);
    rd_chk(3'h2, 8'h05);
    send(16'h0A07);
    rd_chk(3'h2, 8'h05);
    wr(3'h0, 8'h03);
    send(16'h0201);
    rd_chk(3'h2, 8'h05);
    send(16'h8201);
    rd_chk(3'h2, 8'h01);
    wr(3'h0, 8'h01);
    send(16'h8203);
    rd_chk(3'h2, 8'h01);
  endtask
  task t_words;
    wr(3'h1, 8'h00);
    mod_bits_in <= 6'h3F;
    word_chk(16'h8000);
    wr(3'h0, 8'h03);
    word_chk(16'h4000);
    mod_bits_in <= 6'h00;
    word_chk(16'h0000);
  endtask
  task t_cascade;
    wr(3'h1, 8'h03);
    wr(3'h2, 8'h03);
    wr(3'h0, 8'h04);
    send(16'h0A12);
    p = cyc;
    t = cyc;
    n = 0;
    // A gap longer than one sample's four slots marks the start of a sample.
    while (t - p < 1000 && n < 10)
    begin
      p = t;
      frame_rise(t, w);
      n++;
    end
    frame_rise(a, w);
    `CHK("forward slot start", 128, a - t)
    frame_rise(b, w);
    `CHK("next channel start", 136, b - a)
    `CHK("forwarded word", 16'h0212, rx_word)
    frame_rise(c, w);
    `CHK("second forward slot", 128, c - b)
  endtask
  task t_enable;
    port_enable_pin_in <= 1'b0;
    repeat (20) @(posedge clk_in);
    n = 0;
    repeat (40)
    begin
      @(posedge clk_in);
      if (sclk_out !== 1'b0)
        n++;
    end
    `CHK("serial clock stopped", 0, n)
    port_enable_pin_in <= 1'b1;
  endtask
  task final_report;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    t_loop_back();
    t_soft_reset();
    t_rates();
    t_control();
    t_words();
    t_cascade();
    t_enable();
    final_report();
  end
  // The planned traffic needs well under half of this span.
  initial
  begin
    #800000;
    n_errors++;
    $display("BAD watchdog expected finish seen timeout");
    final_report();
  end
endmodule
